// *** rpb_bank.v ***
// Functional notes
// - input I6 priority is a 4-bit read/write value in bits 7:4 of the I5/I6 register.
// - input I5 priority is a 4-bit read/write value in bits 3:0 of the I5/I6 register.
// - register 0x1B holds input I8 priority in bits 7:4 and I7 priority in bits 3:0.
// - in automatic selection a smaller nonzero priority value wins over a larger one.
// - a priority of zero removes that input from automatic selection.
// - with path_bank_select low, accesses reach the main_path copy.
// - with path_bank_select high, accesses reach the separate auxiliary_path copy.
// - after reset the I5/I6 register reads 0x76 in both copies.
`timescale 1ns/10ps
`default_nettype none
`include "rpb_regs.vh"
module rpb_bank (
   input wire clk, // 25 MHz clock
   input wire rst_b, // async reset, active low
   input wire [7:0] addr, // register address
   input wire wr_en, // write strobe, one cycle
   input wire [7:0] wr_data, // write data
   input wire path_bank_select, // bit 4 of source-select register
   output reg [7:0] rd_data, // registered read data
   output reg [1:0] main_best, // main path winning input, 0..3 = I5..I8
   output reg main_valid, // main path has an eligible input
   output reg [1:0] aux_best, // auxiliary path winning input
   output reg aux_valid // auxiliary path has an eligible input
);
   // ----------------------------------------
   // storage and pipeline registers
   // ----------------------------------------
   reg [7:0] main_56_q;
   reg [7:0] main_78_q;
   reg [7:0] aux_56_q;
   reg [7:0] aux_78_q;
   reg [7:0] rd_d;
   reg [2:0] main_sel;
   reg [2:0] aux_sel;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   function hits_five_six;
      input [7:0] a;
      begin
         hits_five_six = (a == `RPB_ADDR_FIVE_SIX);
      end
   endfunction

   function hits_seven_eight;
      input [7:0] a;
      begin
         hits_seven_eight = (a == `RPB_ADDR_SEVEN_EIGHT);
      end
   endfunction

   // ----------------------------------------
   // bank steering
   // ----------------------------------------
   // one strobe per register in each copy; the unselected copy never sees the write
   wire wr_main_56;
   wire wr_main_78;
   wire wr_aux_56;
   wire wr_aux_78;

   assign wr_main_56 = wr_en && !path_bank_select &&
      hits_five_six(addr);
   assign wr_main_78 = wr_en && !path_bank_select &&
      hits_seven_eight(addr);
   assign wr_aux_56 = wr_en && path_bank_select &&
      hits_five_six(addr);
   assign wr_aux_78 = wr_en && path_bank_select &&
      hits_seven_eight(addr);

   // ----------------------------------------
   // per-input priority fields
   // ----------------------------------------
   wire [3:0] main_prio_i5;
   wire [3:0] main_prio_i6;
   wire [3:0] main_prio_i7;
   wire [3:0] main_prio_i8;
   wire [3:0] aux_prio_i5;
   wire [3:0] aux_prio_i6;
   wire [3:0] aux_prio_i7;
   wire [3:0] aux_prio_i8;

   assign main_prio_i5 = main_56_q[`RPB_LO_MSB:`RPB_LO_LSB];
   assign main_prio_i6 = main_56_q[`RPB_HI_MSB:`RPB_HI_LSB];
   assign main_prio_i7 = main_78_q[`RPB_LO_MSB:`RPB_LO_LSB];
   assign main_prio_i8 = main_78_q[`RPB_HI_MSB:`RPB_HI_LSB];
   assign aux_prio_i5 = aux_56_q[`RPB_LO_MSB:`RPB_LO_LSB];
   assign aux_prio_i6 = aux_56_q[`RPB_HI_MSB:`RPB_HI_LSB];
   assign aux_prio_i7 = aux_78_q[`RPB_LO_MSB:`RPB_LO_LSB];
   assign aux_prio_i8 = aux_78_q[`RPB_HI_MSB:`RPB_HI_LSB];

   // ----------------------------------------
   // priority compare
   // ----------------------------------------
   // strict less-than keeps the earlier input on a tie, so I5 beats I8
   // at equal values
   function beats;
      input [3:0] cand;
      input [3:0] best;
      input have;
      begin
         if (cand == 4'h0)
            beats = 1'b0;
         else if (!have)
            beats = 1'b1;
         else
            beats = (cand < best);
      end
   endfunction

   // ----------------------------------------
   // best-priority pick, lowest index on ties
   // ----------------------------------------
   function [2:0] pick;
      input [3:0] p5;
      input [3:0] p6;
      input [3:0] p7;
      input [3:0] p8;
      reg [3:0] best;
      begin
         pick = {1'b0, `RPB_NO_SEL};
         best = 4'h0;
         if (beats(p5, best, pick[2])) begin
            best = p5;
            pick = 3'h4;
         end
         if (beats(p6, best, pick[2])) begin
            best = p6;
            pick = 3'h5;
         end
         if (beats(p7, best, pick[2])) begin
            best = p7;
            pick = 3'h6;
         end
         if (beats(p8, best, pick[2])) begin
            best = p8;
            pick = 3'h7;
         end
      end
   endfunction

   // ----------------------------------------
   // banked storage
   // ----------------------------------------
   // each copy keeps its own value; a write through one bank leaves the
   // other untouched
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         main_56_q <= `RPB_RST_FIVE_SIX;
      else if (wr_main_56)
         main_56_q <= wr_data;
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         aux_56_q <= `RPB_RST_FIVE_SIX;
      else if (wr_aux_56)
         aux_56_q <= wr_data;
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         main_78_q <= `RPB_RST_SEVEN_EIGHT;
      else if (wr_main_78)
         main_78_q <= wr_data;
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         aux_78_q <= `RPB_RST_SEVEN_EIGHT;
      else if (wr_aux_78)
         aux_78_q <= wr_data;
   end

   // ----------------------------------------
   // read back
   // ----------------------------------------
   // reads follow the live bank select, so software sees the copy it writes
   always @* begin
      rd_d = 8'h00;
      if (hits_five_six(addr)) begin
         if (path_bank_select)
            rd_d = aux_56_q;
         else
            rd_d = main_56_q;
      end else if (hits_seven_eight(addr)) begin
         if (path_bank_select)
            rd_d = aux_78_q;
         else
            rd_d = main_78_q;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         rd_data <= 8'h00;
      else
         rd_data <= rd_d;
   end

   // ----------------------------------------
   // automatic selection view
   // ----------------------------------------
   always @* begin
      main_sel = pick(main_prio_i5, main_prio_i6, main_prio_i7, main_prio_i8);
      aux_sel = pick(aux_prio_i5, aux_prio_i6, aux_prio_i7, aux_prio_i8);
   end

   // registered so the outputs never glitch while a priority is rewritten
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         main_best <= 2'h0;
         main_valid <= 1'b0;
      end else begin
         main_best <= main_sel[1:0];
         main_valid <= main_sel[2];
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         aux_best <= 2'h0;
         aux_valid <= 1'b0;
      end else begin
         aux_best <= aux_sel[1:0];
         aux_valid <= aux_sel[2];
      end
   end
endmodule // rpb_bank
`default_nettype wire

// *** rpb_regs.vh ***
`ifndef RPB_REGS_VH
`define RPB_REGS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define RPB_ADDR_FIVE_SIX 8'h1A
`define RPB_ADDR_SEVEN_EIGHT 8'h1B
`define RPB_ADDR_SRC_SEL 8'h4B
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define RPB_PATH_SEL_BIT 4
`define RPB_HI_MSB 7
`define RPB_HI_LSB 4
`define RPB_LO_MSB 3
`define RPB_LO_LSB 0
`define RPB_RST_FIVE_SIX 8'h76
`define RPB_RST_SEVEN_EIGHT 8'h00
`define RPB_NUM_INPUTS 4
`define RPB_NO_SEL 2'h0
`endif

// *** rpb_bank_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module rpb_bank_asserts (
   input wire logic clk, // clock
   input wire logic rst_b, // reset, low
   input wire logic [7:0] addr, // address
   input wire logic wr_en, // write
   input wire logic [7:0] wr_data, // data
   input wire logic path_bank_select, // bank
   input wire logic [7:0] rd_data, // read
   input wire logic [1:0] main_best, // main pick
   input wire logic main_valid, // main ok
   input wire logic [1:0] aux_best, // aux pick
   input wire logic aux_valid // aux ok
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_b);
unmapped_rd_a: assert property (addr[7:1] != 7'h0D
   |=> rd_data == 8'h00) else $error("unmapped read not zero");
write_read_a: assert property (wr_en && addr[7:1] == 7'h0D
   ##1 !wr_en && $stable(addr) && $stable(path_bank_select)
   |=> rd_data == $past(wr_data, 2)) else $error("readback differs");
reset_read_a: assert property ($rose(rst_b) && addr == 8'h1A
   && !wr_en |=> rd_data == 8'h76) else $error("reset value wrong");
reset_pick_a: assert property ($rose(rst_b) |=> main_valid
   && aux_valid && main_best == 2'h0 && aux_best == 2'h0)
   else $error("reset pick wrong");
main_none_a: assert property (!main_valid |-> main_best == 2'h0)
   else $error("main pick without input");
aux_none_a: assert property (!aux_valid |-> aux_best == 2'h0)
   else $error("aux pick without input");
main_kept_a: assert property (($past(rst_b)
   && !(wr_en && !path_bank_select)) [*2]
   |=> $stable({main_valid, main_best})) else $error("main copy moved");
aux_kept_a: assert property (($past(rst_b)
   && !(wr_en && path_bank_select)) [*2]
   |=> $stable({aux_valid, aux_best})) else $error("aux copy moved");
endmodule // rpb_bank_asserts
`default_nettype wire

// *** rpb_bank_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; \
   $display("wrong value at %0t: %h, expected %h", $time, a, e); end end
module rpb_bank_bench;
logic clk = 1'b0, rst_b = 1'b0, wr_en = 1'b0, sel = 1'b0, mv, av;
logic [7:0] addr = 8'h1A, wd = 8'h00, rd;
logic [1:0] mb, ab;
int err_count = 0, n_compared = 0;
always #20 clk = ~clk;
rpb_bank i_dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_en(wr_en),
   .wr_data(wd), .path_bank_select(sel), .rd_data(rd), .main_best(mb),
   .main_valid(mv), .aux_best(ab), .aux_valid(av));
task wr(input logic s, input logic [7:0] a, d);
   @(posedge clk); sel <= s; addr <= a; wd <= d; wr_en <= 1'b1;
   @(posedge clk); wr_en <= 1'b0;
endtask
task rc(input logic s, input logic [7:0] a, e);
   @(posedge clk); sel <= s; addr <= a;
   @(posedge clk); #1 `CHK(rd, e)
endtask
task end_of_test();
   $display("compared %0d, wrong %0d", n_compared, err_count);
   if (err_count == 0 && n_compared > 0) $display("All tests passed");
   else $display("Some tests failed");
   $finish;
endtask
initial begin
   repeat (3) @(posedge clk);
   rst_b <= 1'b1;
   rc(0, 8'h1A, 8'h76);
   rc(1, 8'h1A, 8'h76);
   `CHK({mv, mb, av, ab}, 6'h24)
   $display("test reset done");
   wr(0, 8'h1B, 8'h21);
   wr(1, 8'h1B, 8'h39);
   wr(1, 8'h1A, 8'h00);
   rc(0, 8'h1B, 8'h21);
   rc(1, 8'h1B, 8'h39);
   rc(1, 8'h4B, 8'h00);
   `CHK({mv, mb, av, ab}, 6'h37)
   wr(0, 8'h1B, 8'h00);
   wr(1, 8'h1B, 8'h00);
   wr(0, 8'h1A, 8'h5A);
   rc(0, 8'h1A, 8'h5A);
   `CHK({mv, mb, av}, 4'hA)
   $display("test banks done");
   rst_b <= 1'b0;
   repeat (3) @(posedge clk);
   rst_b <= 1'b1;
   rc(0, 8'h1A, 8'h76);
   rc(1, 8'h1A, 8'h76);
   rc(0, 8'h1B, 8'h00);
   rc(1, 8'h1B, 8'h00);
   `CHK({mv, mb, av, ab}, 6'h24)
   $display("test reset again done");
   end_of_test();
end
endmodule // rpb_bank_bench
bind rpb_bank rpb_bank_asserts i_chk (.*);
`default_nettype wire
